// File: core/fault_and_mfg_status_bank.sv
// module: saved permanent-failure flags, manufacturing status word, apb slave
//
// Chosen here: the APB interface to the registers and the register addresses.
`timescale 1ns/10ps

// How it works
// - second register bit 7 holds latched discharge short-circuit fault.
// - second register bit 4 active imbalance, bit 3 relaxed imbalance.
// - second register bit 2 holds secondary-protector fault.
// - second register bit 1 discharge fet fault, bit 0 charge fet fault.
// - third register bit 7 commanded fault, bit 6 comparator mux fault.
// - third register bit 5 ground supply fault, bit 4 reference voltage fault.
// - third register bit 3 holds slow oscillator monitor fault.
// - third register bits 2,1,0: instruction rom, data rom, one-time memory.
// - fourth register bit 0 top-of-stack fault, upper seven bits read zero.
// - manufacturing word is 16 bits; bits 15..8 and 3 read zero.
// - bit 7 permits runtime one-time memory writes; manufacturing record needs full access.
// - one-time memory writes only while stack voltage and temperature within limits.
// - configuration-update mode allows programming even with bit 7 cleared.
// - bit 6 enables fault checks; when clear no fault may trigger.
// - bit 4 zero: test mode, fets on only when test commands say.
// - bit 4 one: normal fet control, test commands ignored.
// - safety forces off, or on for body diode, override test settings.
// - bit 5 shows predischarge test enable, changed only by its command.
// - bits 2,1,0 show discharge, charge, precharge test enables, each own command.
module fault_and_mfg_status_bank
    import fault_bank_pkg::*;
#(
    parameter int ADDR_WIDTH = 8
) (
    // apb clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // apb slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [ADDR_WIDTH-1:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // fault detector events, second register group
    input wire logic latched_short_fault,
    input wire logic imbalance_active_fault,
    input wire logic imbalance_relax_fault,
    input wire logic secondary_protector_fault,
    input wire logic discharge_fet_fault,
    input wire logic charge_fet_fault,
    // fault detector events, third register group
    input wire logic commanded_fault,
    input wire logic comparator_mux_fault,
    input wire logic ground_supply_fault,
    input wire logic reference_voltage_fault,
    input wire logic slow_oscillator_fault,
    input wire logic instruction_rom_fault,
    input wire logic data_rom_fault,
    input wire logic onetime_memory_fault,
    // fault detector event, fourth register group
    input wire logic top_of_stack_fault,
    // clearing of saved faults, done by the outside
    input wire logic saved_fault_clear,
    // one-time memory programming
    input wire logic prog_request,
    input wire logic [1:0] prog_kind,
    input wire logic unrestricted_access_mode,
    input wire logic config_update_mode,
    input wire logic stack_voltage_ok,
    input wire logic temperature_ok,
    output logic prog_go,
    output logic prog_refused,
    // fet control
    input wire logic [FET_COUNT-1:0] normal_fet_request,
    input wire logic [FET_COUNT-1:0] safety_force_off,
    input wire logic [FET_COUNT-1:0] safety_force_on,
    output logic [FET_COUNT-1:0] fet_drive,
    output logic fet_test_mode,
    // summary
    output logic permanent_failure
);

    typedef struct packed {
        logic [31:0] prdata;
        logic pready;
        logic pslverr;
        logic runtime_program_enable;
        logic fault_check_enable;
        logic normal_fet_control;
        logic [FET_COUNT-1:0] test_on;
        logic prog_go;
        logic prog_refused;
        logic [FET_COUNT-1:0] fet_drive;
        logic permanent_failure;
    } state_t;

    state_t state_q;
    state_t state_d;

    logic [FAULT_COUNT-1:0] fault_events;
    logic [FAULT_COUNT-1:0] fault_flags;
    logic [7:0] second_reg;
    logic [7:0] third_reg;
    logic [7:0] fourth_reg;
    logic [15:0] mfg_word;
    logic setup_phase;
    logic write_strobe;
    logic prog_allowed;
    logic [FET_COUNT-1:0] fet_source;

    // full byte offset of an apb address, bits above the map must be zero
    function automatic logic addr_hit(input logic [ADDR_WIDTH-1:0] addr, input logic [7:0] ofs);
        addr_hit = (addr == ADDR_WIDTH'(ofs));
    endfunction : addr_hit

    // true for any address that holds a register
    function automatic logic addr_mapped(input logic [ADDR_WIDTH-1:0] addr);
        addr_mapped = addr_hit(addr, SAVED_FAULT_SECOND_OFS) ||
                      addr_hit(addr, SAVED_FAULT_THIRD_OFS) ||
                      addr_hit(addr, SAVED_FAULT_FOURTH_OFS) ||
                      addr_hit(addr, MANUFACTURING_STATUS_OFS) ||
                      addr_hit(addr, MFG_CONTROL_OFS) ||
                      addr_hit(addr, FET_TEST_COMMAND_OFS);
    endfunction : addr_mapped

    // detector events packed in register order: fourth, third, second
    assign fault_events = {
        top_of_stack_fault,
        commanded_fault,
        comparator_mux_fault,
        ground_supply_fault,
        reference_voltage_fault,
        slow_oscillator_fault,
        instruction_rom_fault,
        data_rom_fault,
        onetime_memory_fault,
        latched_short_fault,
        imbalance_active_fault,
        imbalance_relax_fault,
        secondary_protector_fault,
        discharge_fet_fault,
        charge_fet_fault
    };

    // saved faults only latch while checks are enabled
    sticky_flags #(
        .WIDTH(FAULT_COUNT)
    ) u_saved_faults (
        .pclk(pclk),
        .presetn(presetn),
        .enable(state_q.fault_check_enable),
        .clear(saved_fault_clear),
        .set(fault_events),
        .flags(fault_flags)
    );

    // second register: bits 6 and 5 read zero
    always_comb begin
        second_reg = 8'h00;
        second_reg[LATCHED_SHORT_BIT] = fault_flags[5];
        second_reg[IMBALANCE_ACTIVE_BIT] = fault_flags[4];
        second_reg[IMBALANCE_RELAX_BIT] = fault_flags[3];
        second_reg[SECONDARY_PROTECTOR_BIT] = fault_flags[2];
        second_reg[DISCHARGE_FET_FAULT_BIT] = fault_flags[1];
        second_reg[CHARGE_FET_FAULT_BIT] = fault_flags[0];
    end

    // third register: all eight bits used
    always_comb begin
        third_reg = 8'h00;
        third_reg[COMMANDED_BIT] = fault_flags[13];
        third_reg[COMPARATOR_MUX_BIT] = fault_flags[12];
        third_reg[GROUND_SUPPLY_BIT] = fault_flags[11];
        third_reg[REFERENCE_VOLTAGE_BIT] = fault_flags[10];
        third_reg[SLOW_OSCILLATOR_BIT] = fault_flags[9];
        third_reg[INSTRUCTION_ROM_BIT] = fault_flags[8];
        third_reg[DATA_ROM_BIT] = fault_flags[7];
        third_reg[ONETIME_MEMORY_BIT] = fault_flags[6];
    end

    // fourth register: only bit 0, reserved bits stay zero
    always_comb begin
        fourth_reg = 8'h00;
        fourth_reg[TOP_OF_STACK_BIT] = fault_flags[14];
    end

    // manufacturing word: upper byte and bit 3 read zero
    always_comb begin
        mfg_word = 16'h0000;
        mfg_word[RUNTIME_PROGRAM_ENABLE_BIT] = state_q.runtime_program_enable;
        mfg_word[FAULT_CHECK_ENABLE_BIT] = state_q.fault_check_enable;
        mfg_word[PREDISCHARGE_TEST_BIT] = state_q.test_on[FET_PREDISCHARGE];
        mfg_word[NORMAL_FET_CONTROL_BIT] = state_q.normal_fet_control;
        mfg_word[DISCHARGE_TEST_BIT] = state_q.test_on[FET_DISCHARGE];
        mfg_word[CHARGE_TEST_BIT] = state_q.test_on[FET_CHARGE];
        mfg_word[PRECHARGE_TEST_BIT] = state_q.test_on[FET_PRECHARGE];
    end

    // apb phases; pready is high in every access phase, so no wait states
    assign setup_phase = psel && !penable;
    assign write_strobe = psel && penable && state_q.pready && pwrite;

    // limits gate every write; config update bypasses the runtime enable bit
    always_comb begin
        prog_allowed = 1'b0;
        if (config_update_mode) begin
            prog_allowed = 1'b1;
        end else if (state_q.runtime_program_enable) begin
            // manufacturing record only on request with full access
            if (prog_kind == 2'(PROG_MANUFACTURING_RECORD)) begin
                prog_allowed = unrestricted_access_mode;
            end else begin
                prog_allowed = (prog_kind != 2'(PROG_RESERVED));
            end
        end
        prog_allowed = prog_allowed && stack_voltage_ok && temperature_ok;
    end

    // fet source: normal control, or the test bits in test mode
    always_comb begin
        if (state_q.normal_fet_control) begin
            fet_source = normal_fet_request;
        end else begin
            fet_source = state_q.test_on;
        end
    end

    // next state: bus answer, controls, programming strobes, fet drive
    always_comb begin
        state_d = state_q;
        state_d.prog_go = 1'b0;
        state_d.prog_refused = 1'b0;
        // answer prepared in the setup cycle so outputs come from flops
        state_d.pready = setup_phase;
        state_d.pslverr = setup_phase && !addr_mapped(paddr);
        state_d.prdata = 32'h0000_0000;
        if (setup_phase && !pwrite) begin
            if (addr_hit(paddr, SAVED_FAULT_SECOND_OFS)) begin
                state_d.prdata = {24'h00_0000, second_reg};
            end else if (addr_hit(paddr, SAVED_FAULT_THIRD_OFS)) begin
                state_d.prdata = {24'h00_0000, third_reg};
            end else if (addr_hit(paddr, SAVED_FAULT_FOURTH_OFS)) begin
                state_d.prdata = {24'h00_0000, fourth_reg};
            end else if (addr_hit(paddr, MANUFACTURING_STATUS_OFS)) begin
                state_d.prdata = {16'h0000, mfg_word};
            end else if (addr_hit(paddr, MFG_CONTROL_OFS)) begin
                state_d.prdata = {16'h0000, mfg_word};
            end
        end
        // control writes: only the three mode bits are writable here
        if (write_strobe && addr_hit(paddr, MFG_CONTROL_OFS)) begin
            state_d.runtime_program_enable = pwdata[RUNTIME_PROGRAM_ENABLE_BIT];
            state_d.fault_check_enable = pwdata[FAULT_CHECK_ENABLE_BIT];
            state_d.normal_fet_control = pwdata[NORMAL_FET_CONTROL_BIT];
        end
        // test commands change only their own bit, and only in test mode
        if (write_strobe && addr_hit(paddr, FET_TEST_COMMAND_OFS) &&
                !state_q.normal_fet_control) begin
            if (pwdata[CMD_PRECHARGE_BIT]) begin
                state_d.test_on[FET_PRECHARGE] = pwdata[CMD_VALUE_BIT];
            end
            if (pwdata[CMD_CHARGE_BIT]) begin
                state_d.test_on[FET_CHARGE] = pwdata[CMD_VALUE_BIT];
            end
            if (pwdata[CMD_DISCHARGE_BIT]) begin
                state_d.test_on[FET_DISCHARGE] = pwdata[CMD_VALUE_BIT];
            end
            if (pwdata[CMD_PREDISCHARGE_BIT]) begin
                state_d.test_on[FET_PREDISCHARGE] = pwdata[CMD_VALUE_BIT];
            end
        end
        // a request yields exactly one of go or refused
        if (prog_request) begin
            state_d.prog_go = prog_allowed;
            state_d.prog_refused = !prog_allowed;
        end
        // force on beats force off, both beat the chosen source
        state_d.fet_drive = safety_force_on | (fet_source & ~safety_force_off);
        state_d.permanent_failure = |fault_flags;
    end

    // single register stage for all state
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_q <= '{
                prdata: 32'h0000_0000,
                pready: 1'b0,
                pslverr: 1'b0,
                runtime_program_enable: RUNTIME_PROGRAM_ENABLE_RST,
                fault_check_enable: FAULT_CHECK_ENABLE_RST,
                normal_fet_control: NORMAL_FET_CONTROL_RST,
                test_on: FET_TEST_RST,
                prog_go: 1'b0,
                prog_refused: 1'b0,
                fet_drive: 4'h0,
                permanent_failure: 1'b0
            };
        end else begin
            state_q <= state_d;
        end
    end

    // outputs straight from the state flops
    assign prdata = state_q.prdata;
    assign pready = state_q.pready;
    assign pslverr = state_q.pslverr;
    assign prog_go = state_q.prog_go;
    assign prog_refused = state_q.prog_refused;
    assign fet_drive = state_q.fet_drive;
    assign fet_test_mode = !state_q.normal_fet_control;
    assign permanent_failure = state_q.permanent_failure;

endmodule : fault_and_mfg_status_bank

// File: core/sticky_flags.sv
// module: bank of sticky flags, set wins over clear
`timescale 1ns/10ps
module sticky_flags #(
    parameter int WIDTH = 8
) (
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // control
    input wire logic enable,
    input wire logic clear,
    input wire logic [WIDTH-1:0] set,
    // state
    output logic [WIDTH-1:0] flags
);

    typedef struct packed {
        logic [WIDTH-1:0] flags;
    } state_t;

    state_t state_q;
    state_t state_d;

    // a set arriving with the clear is kept, so no event is lost
    always_comb begin
        state_d = state_q;
        if (clear) begin
            state_d.flags = '0;
        end
        if (enable) begin
            state_d.flags = state_d.flags | set;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_q <= '0;
        end else begin
            state_q <= state_d;
        end
    end

    assign flags = state_q.flags;

endmodule : sticky_flags

// File: pkg/fault_bank_pkg.sv
// package: register map, field positions, reset values for the saved-fault bank
package fault_bank_pkg;

    // apb register byte offsets
    localparam logic [7:0] SAVED_FAULT_SECOND_OFS = 8'h00;
    localparam logic [7:0] SAVED_FAULT_THIRD_OFS = 8'h04;
    localparam logic [7:0] SAVED_FAULT_FOURTH_OFS = 8'h08;
    localparam logic [7:0] MANUFACTURING_STATUS_OFS = 8'h0C;
    localparam logic [7:0] MFG_CONTROL_OFS = 8'h10;
    localparam logic [7:0] FET_TEST_COMMAND_OFS = 8'h14;

    // second saved-fault register fields
    localparam int LATCHED_SHORT_BIT = 7;
    localparam int IMBALANCE_ACTIVE_BIT = 4;
    localparam int IMBALANCE_RELAX_BIT = 3;
    localparam int SECONDARY_PROTECTOR_BIT = 2;
    localparam int DISCHARGE_FET_FAULT_BIT = 1;
    localparam int CHARGE_FET_FAULT_BIT = 0;

    // third saved-fault register fields
    localparam int COMMANDED_BIT = 7;
    localparam int COMPARATOR_MUX_BIT = 6;
    localparam int GROUND_SUPPLY_BIT = 5;
    localparam int REFERENCE_VOLTAGE_BIT = 4;
    localparam int SLOW_OSCILLATOR_BIT = 3;
    localparam int INSTRUCTION_ROM_BIT = 2;
    localparam int DATA_ROM_BIT = 1;
    localparam int ONETIME_MEMORY_BIT = 0;

    // fourth saved-fault register field
    localparam int TOP_OF_STACK_BIT = 0;

    // manufacturing status word fields
    localparam int RUNTIME_PROGRAM_ENABLE_BIT = 7;
    localparam int FAULT_CHECK_ENABLE_BIT = 6;
    localparam int PREDISCHARGE_TEST_BIT = 5;
    localparam int NORMAL_FET_CONTROL_BIT = 4;
    localparam int DISCHARGE_TEST_BIT = 2;
    localparam int CHARGE_TEST_BIT = 1;
    localparam int PRECHARGE_TEST_BIT = 0;

    // test command register fields: one select bit per fet, and the value to load
    localparam int CMD_PRECHARGE_BIT = 0;
    localparam int CMD_CHARGE_BIT = 1;
    localparam int CMD_DISCHARGE_BIT = 2;
    localparam int CMD_PREDISCHARGE_BIT = 3;
    localparam int CMD_VALUE_BIT = 4;

    // fet vector order used on all fet ports
    localparam int FET_PRECHARGE = 0;
    localparam int FET_CHARGE = 1;
    localparam int FET_DISCHARGE = 2;
    localparam int FET_PREDISCHARGE = 3;
    localparam int FET_COUNT = 4;

    // number of saved-fault flags (6 + 8 + 1)
    localparam int FAULT_COUNT = 15;

    // reset values of the software controls
    localparam logic RUNTIME_PROGRAM_ENABLE_RST = 1'b0;
    localparam logic FAULT_CHECK_ENABLE_RST = 1'b0;
    localparam logic NORMAL_FET_CONTROL_RST = 1'b1;
    localparam logic [FET_COUNT-1:0] FET_TEST_RST = 4'h0;

    // kinds of runtime one-time memory write request
    typedef enum logic [1:0] {
        PROG_FAULT_STATE,
        PROG_FUSE_STATE,
        PROG_MANUFACTURING_RECORD,
        PROG_RESERVED
    } prog_kind_t;

endpackage : fault_bank_pkg

// File: tb/apb_host.sv
// host model: apb master issuing register commands to the bank
`timescale 1ns/10ps
module apb_host (
    // clock
    input wire logic pclk,
    // apb answer
    input wire logic pready,
    // apb request
    output logic psel,
    output logic penable,
    output logic pwrite,
    output logic [7:0] paddr,
    output logic [31:0] pwdata
);
    // idle bus at time zero
    initial begin
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h0;
        pwdata = 32'h0;
    end

    // one transfer; caller enters just after a rising edge
    task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        // no assumed latency, only the bench watchdog ends this wait
        while (pready !== 1'b1) begin
            @(posedge pclk);
        end
        // released lines show the inverse so stale values never look valid
        psel <= 1'b0;
        penable <= 1'b0;
        paddr <= ~a;
        pwdata <= ~d;
        @(posedge pclk);
    endtask : xfer
endmodule : apb_host

// File: tb/fault_bank_properties.sv
// checker: timing relations at the ports of the saved-fault bank
`timescale 1ns/10ps
module bank_properties
    import fault_bank_pkg::*;
(
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // apb
    input wire logic psel,
    input wire logic penable,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    // programming and clearing
    input wire logic saved_fault_clear,
    input wire logic prog_request,
    input wire logic [1:0] prog_kind,
    input wire logic config_update_mode,
    input wire logic stack_voltage_ok,
    input wire logic temperature_ok,
    input wire logic prog_go,
    input wire logic prog_refused,
    // fets and summary
    input wire logic [FET_COUNT-1:0] normal_fet_request,
    input wire logic [FET_COUNT-1:0] safety_force_off,
    input wire logic [FET_COUNT-1:0] safety_force_on,
    input wire logic [FET_COUNT-1:0] fet_drive,
    input wire logic fet_test_mode,
    input wire logic permanent_failure
);
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    a_ready_setup: assert property (psel && !penable |=> pready)
        else $error("no ready after setup");
    a_err_ready: assert property (pslverr |-> pready)
        else $error("error without ready");
    a_rdata_idle: assert property (!pready |-> prdata == 32'h0)
        else $error("read data outside access");
    a_prog_one: assert property (prog_request |=> prog_go != prog_refused)
        else $error("programming verdict missing or double");
    a_prog_limits: assert property ($past(presetn) && prog_go |->
        $past(stack_voltage_ok) && $past(temperature_ok))
        else $error("programming outside limits");
    a_prog_config: assert property (prog_request && config_update_mode && stack_voltage_ok
        && temperature_ok && prog_kind != 2'h3 |=> prog_go)
        else $error("config update programming refused");
    a_fet_normal: assert property ($past(presetn) && !$past(fet_test_mode) |-> fet_drive ==
        ($past(safety_force_on) | ($past(normal_fet_request) & ~$past(safety_force_off))))
        else $error("normal fet drive wrong");
    a_force_on: assert property ($past(presetn) |->
        (fet_drive & $past(safety_force_on)) == $past(safety_force_on))
        else $error("forced on fet not driven");
    a_force_off: assert property ($past(presetn) |->
        (fet_drive & $past(safety_force_off) & ~$past(safety_force_on)) == 4'h0)
        else $error("forced off fet driven");
    a_pf_sticky: assert property ($fell(permanent_failure) |-> $past(saved_fault_clear, 2))
        else $error("saved fault dropped without clear");
endmodule : bank_properties

bind fault_and_mfg_status_bank bank_properties chk_i (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .saved_fault_clear(saved_fault_clear), .prog_request(prog_request),
    .prog_kind(prog_kind), .config_update_mode(config_update_mode),
    .stack_voltage_ok(stack_voltage_ok), .temperature_ok(temperature_ok),
    .prog_go(prog_go), .prog_refused(prog_refused), .normal_fet_request(normal_fet_request),
    .safety_force_off(safety_force_off), .safety_force_on(safety_force_on),
    .fet_drive(fet_drive), .fet_test_mode(fet_test_mode),
    .permanent_failure(permanent_failure));

// File: tb/tb_fault_and_mfg_status_bank.sv
// testbench: saved-fault bank driven over apb by the host model
`timescale 1ns/10ps
module tb_fault_and_mfg_status_bank;
    import fault_bank_pkg::*;
    logic pclk, psel, penable, pwrite, pready, pslverr, pgo, pref, ftm, pf;
    logic presetn = 1'b0, clr = 1'b0, preq = 1'b0, ua = 1'b0, cfg = 1'b0, vok = 1'b0;
    logic tok = 1'b0;
    logic [1:0] pk = 2'h0;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata;
    logic [14:0] fv = 15'h0, acc;
    logic [3:0] nrq = 4'h0, off = 4'h0, on = 4'h0, fd;
    logic [15:0] mw = 16'h0010;
    logic [32:0] rq[$];
    logic [1:0] pq[$];
    int miscompares = 0, n_checks = 0;

    apb_host host (.pclk(pclk), .pready(pready), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata));
    fault_and_mfg_status_bank uut (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .latched_short_fault(fv[0]),
        .imbalance_active_fault(fv[1]), .imbalance_relax_fault(fv[2]),
        .secondary_protector_fault(fv[3]), .discharge_fet_fault(fv[4]),
        .charge_fet_fault(fv[5]), .commanded_fault(fv[6]), .comparator_mux_fault(fv[7]),
        .ground_supply_fault(fv[8]), .reference_voltage_fault(fv[9]),
        .slow_oscillator_fault(fv[10]), .instruction_rom_fault(fv[11]),
        .data_rom_fault(fv[12]), .onetime_memory_fault(fv[13]),
        .top_of_stack_fault(fv[14]), .saved_fault_clear(clr), .prog_request(preq),
        .prog_kind(pk), .unrestricted_access_mode(ua), .config_update_mode(cfg),
        .stack_voltage_ok(vok), .temperature_ok(tok), .prog_go(pgo), .prog_refused(pref),
        .normal_fet_request(nrq), .safety_force_off(off), .safety_force_on(on),
        .fet_drive(fd), .fet_test_mode(ftm), .permanent_failure(pf));

    initial begin
        pclk = 1'b0;
        forever #2 pclk = ~pclk;
    end

    task automatic chk(input string nm, input logic [32:0] e, input logic [32:0] g);
        n_checks++;
        if (g !== e) begin
            miscompares++;
            $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
        end
    endtask : chk

    // read answers and verdicts are matched against the oldest note
    always @(posedge pclk) begin
        if (presetn && psel && penable && pready === 1'b1 && !pwrite)
            chk("read", rq.size() ? rq.pop_front() : 33'h0, {pslverr, prdata});
        if (presetn && (pgo === 1'b1 || pref === 1'b1))
            chk("prog", pq.size() ? pq.pop_front() : 2'h3, {pgo, pref});
    end

    task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic err = 1'b0);
        rq.push_back({err, e});
        host.xfer(1'b0, a, 32'h0);
    endtask : rd

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        host.xfer(1'b1, a, d);
    endtask : wr

    task automatic rd_faults(input logic [14:0] a);
        rd(SAVED_FAULT_SECOND_OFS, {24'h0, a[0], 2'h0, a[1], a[2], a[3], a[4], a[5]});
        rd(SAVED_FAULT_THIRD_OFS, {24'h0, a[6], a[7], a[8], a[9], a[10], a[11], a[12], a[13]});
        rd(SAVED_FAULT_FOURTH_OFS, {31'h0, a[14]});
        chk("permanent_failure", {32'h0, |a}, {32'h0, pf});
    endtask : rd_faults

    // random filler in the other bits must not reach the status word
    task automatic setctl(input logic b7, input logic b6, input logic b4);
        wr(MFG_CONTROL_OFS, ($urandom() & 32'hFFFFFF2F) | {24'h0, b7, b6, 1'h0, b4, 4'h0});
        mw[7] = b7;
        mw[6] = b6;
        mw[4] = b4;
        rd(MANUFACTURING_STATUS_OFS, {16'h0, mw});
    endtask : setctl

    task automatic cmd(input logic [3:0] s, input logic v);
        wr(FET_TEST_COMMAND_OFS, {27'h0, v, s});
        if (!mw[4]) begin
            for (int k = 0; k < 3; k++) if (s[k]) mw[k] = v;
            if (s[3]) mw[5] = v;
        end
        rd(MANUFACTURING_STATUS_OFS, {16'h0, mw});
    endtask : cmd

    task automatic fets(input logic frc);
        logic [3:0] n, o, f;
        n = 4'($urandom());
        o = frc ? 4'($urandom()) : 4'h0;
        f = frc ? 4'($urandom()) : 4'h0;
        nrq <= n;
        off <= o;
        on <= f;
        repeat (2) @(posedge pclk);
        chk("fet_drive", {29'h0, f | ((mw[4] ? n : {mw[5], mw[2:0]}) & ~o)}, {29'h0, fd});
        chk("fet_test_mode", {32'h0, !mw[4]}, {32'h0, ftm});
    endtask : fets

    task automatic pulse(input logic [14:0] v);
        fv <= v;
        @(posedge pclk);
        fv <= 15'h0;
        @(posedge pclk);
    endtask : pulse

    task automatic results();
        $display("checks %0d miscompares %0d", n_checks, miscompares);
        if (miscompares == 0 && n_checks > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask : results

    // hang guard, far beyond the few hundred cycles of the run
    initial begin
        #100000;
        miscompares++;
        results();
    end

    initial begin
        logic [3:0] r;
        logic [1:0] k;
        logic ok;
        void'($urandom(32'h60AFA0DB));
        repeat (12) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        rd_faults(15'h0);
        rd(MANUFACTURING_STATUS_OFS, 32'h10);
        rd(FET_TEST_COMMAND_OFS, 32'h0);
        rd(8'h20, 32'h0, 1'b1);
        pulse(15'h7FFF);
        rd_faults(15'h0);
        setctl(1'b1, 1'b1, 1'b1);
        acc = 15'h0;
        for (int i = 0; i < 15; i++) begin
            pulse(15'h1 << i);
            acc[i] = 1'b1;
            rd_faults(acc);
        end
        wr(SAVED_FAULT_SECOND_OFS, 32'hFFFFFFFF);
        rd_faults(acc);
        clr <= 1'b1;
        @(posedge pclk);
        clr <= 1'b0;
        @(posedge pclk);
        rd_faults(15'h0);
        cmd(4'hF, 1'b1);
        fets(1'b0);
        setctl(1'b1, 1'b1, 1'b0);
        for (int j = 0; j < 4; j++) begin
            cmd(4'h1 << j, 1'b1);
            fets(1'b0);
        end
        cmd(4'h6, 1'b0);
        repeat (2) fets(1'b1);
        setctl(1'b1, 1'b1, 1'b1);
        fets(1'b1);
        // half the requests with runtime writes enabled, half without
        for (int j = 0; j < 40; j++) begin
            if (j == 20) setctl(1'b0, 1'b1, 1'b1);
            r = 4'($urandom()) | 4'h3 & 4'($urandom());
            // every kind, the reserved one included, is requested
            k = 2'($urandom());
            ok = r[1] & r[0] & (r[3] | (mw[7] & (k[1] == 1'b0 | (k == 2'h2 & r[2]))));
            pq.push_back({ok, !ok});
            {cfg, ua, vok, tok} <= r;
            pk <= k;
            preq <= 1'b1;
            @(posedge pclk);
            preq <= 1'b0;
            @(posedge pclk);
        end
        presetn <= 1'b0;
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        mw = 16'h0010;
        @(posedge pclk);
        rd(MANUFACTURING_STATUS_OFS, 32'h10);
        rd_faults(15'h0);
        repeat (4) @(posedge pclk);
        chk("pending", 33'h0, 33'(rq.size() + pq.size()));
        results();
    end
endmodule : tb_fault_and_mfg_status_bank
